// ===== logic/cache_sync_pkg.sv
// Purpose: shared constants, types and helpers for the second-level
//          cache synchronize sweep and first-level write policy block
// Assumes: two-way set associative tag array, coherency states coded
//          in two bits, one clock domain

package cache_sync_pkg;

   // -----------------------------------------------------------------
   // geometry and encodings
   // -----------------------------------------------------------------
   localparam int TAG_WIDTH = 12;
   localparam int SET_WIDTH = 11;

   localparam logic [1:0] COH_INVALID = 2'h0;
   localparam logic [1:0] COH_SHARED  = 2'h1;
   localparam logic [1:0] COH_EXCL    = 2'h2;
   localparam logic [1:0] COH_MOD     = 2'h3;

   localparam logic POLICY_WB   = 1'b1;   // writeback
   localparam logic POLICY_WT   = 1'b0;   // writethrough
   localparam logic LOW_ACTIVE  = 1'b0;
   localparam logic LOW_IDLE    = 1'b1;
   localparam logic [SET_WIDTH-1:0] SET_LAST  = {SET_WIDTH{1'b1}};
   localparam logic [SET_WIDTH-1:0] SET_FIRST = {SET_WIDTH{1'b0}};
   localparam logic [SET_WIDTH-1:0] SET_STEP  = {{(SET_WIDTH-1){1'b0}}, 1'b1};

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [9:0] {
      CTL_INIT     = 10'h001,
      CTL_IDLE     = 10'h002,
      CTL_LOOKUP   = 10'h004,
      CTL_FILL     = 10'h008,
      CTL_SW_READ  = 10'h010,
      CTL_SW_LOAD  = 10'h020,
      CTL_SW_CHECK = 10'h040,
      CTL_SW_INQ   = 10'h080,
      CTL_SW_MEMW  = 10'h100,
      CTL_SW_DONE  = 10'h200
   } ctl_state_type;

   typedef struct packed {
      logic [1:0]           coh;
      logic [TAG_WIDTH-1:0] tag;
   } line_type;

   typedef struct packed {
      logic     recent_use_bit;
      line_type way1;
      line_type way0;
   } entry_type;

   localparam int ENTRY_WIDTH = $bits(entry_type);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic line_type get_line(input entry_type e,
                                         input logic      w);
      get_line = w ? e.way1 : e.way0;
   endfunction

   function automatic entry_type put_line(input entry_type e,
                                          input logic      w,
                                          input line_type  l);
      entry_type r;
      r = e;
      if (w) begin
         r.way1 = l;
      end else begin
         r.way0 = l;
      end
      put_line = r;
   endfunction

endpackage

// ===== logic/tag_store.sv
// Purpose: single-port tag and state store, one entry per set
// Assumes: read address presented in one cycle, data valid the next
// Notes:   array contents are not reset; the controller clears them

`timescale 1ns/10ps
`default_nettype none

module tag_store #(
   parameter int ADDR_BITS = 11,
   parameter int DATA_BITS = 29
) (
   input  wire logic                 ref_clk,
   input  wire logic                 reset_n,
   input  wire logic [ADDR_BITS-1:0] addr,
   input  wire logic                 wr_en,
   input  wire logic [DATA_BITS-1:0] wr_data,
   output var  logic [DATA_BITS-1:0] rd_data
);

   typedef struct packed {
      logic [DATA_BITS-1:0] rd_data;
   } store_type;

   logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];
   store_type            st_reg;
   store_type            st_next;

   // registered read port
   always_comb begin
      st_next = st_reg;
      st_next.rd_data = mem[addr];
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // array write
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
   end

   assign rd_data = st_reg.rd_data;

endmodule

`default_nettype wire

// ===== logic/cache_sync_ctl.sv
// Purpose: second-level cache control for the synchronize sweep, way
//          select and array write to the data SRAM, and first-level
//          line write policy on fills
// Assumes: processor and memory bus handshakes are synchronous to
//          ref_clk; memory bus controller moves the data itself
// Notes:   a processor strobe while busy is not taken

`timescale 1ns/10ps
`default_nettype none

module cache_sync_ctl
   import cache_sync_pkg::*;
(
   input  wire logic                           ref_clk,
   input  wire logic                           reset_n,
   input  wire logic                           sync_req_n,
   input  wire logic                           cpu_address_strobe_n,
   input  wire logic                           cpu_write_read,
   input  wire logic [TAG_WIDTH+SET_WIDTH-1:0] cpu_addr,
   input  wire logic                           cpu_inquire_done,
   input  wire logic                           mem_fill_done,
   input  wire logic                           mem_write_done,
   output var  logic                           sync_busy,
   output var  logic                           ctl_ready,
   output var  logic                           inquire_strobe_n,
   output var  logic                           mem_fill_req,
   output var  logic                           mem_write_req,
   output var  logic [TAG_WIDTH+SET_WIDTH-1:0] line_addr,
   output var  logic                           access_hit,
   output var  logic                           sram_way,
   output var  logic                           sram_array_write_ctl_n,
   output var  logic                           line_write_policy
);

   typedef struct packed {
      ctl_state_type                  fsm;
      logic [SET_WIDTH-1:0]           idx;
      logic                           way;
      entry_type                      entry;
      logic [TAG_WIDTH-1:0]           tag;
      logic                           wr;
      logic                           sync_prev_n;
      logic                           sync_busy;
      logic                           ctl_ready;
      logic                           inquire_strobe_n;
      logic                           mem_fill_req;
      logic                           mem_write_req;
      logic [TAG_WIDTH+SET_WIDTH-1:0] line_addr;
      logic                           access_hit;
      logic                           sram_way;
      logic                           sram_array_write_ctl_n;
      logic                           line_write_policy;
   } ctl_type;

   localparam ctl_type CTL_RESET = '{
      fsm: CTL_INIT, idx: SET_FIRST, way: 1'b0, entry: '0,
      tag: '0, wr: 1'b0, sync_prev_n: LOW_IDLE, sync_busy: 1'b0,
      ctl_ready: 1'b0, inquire_strobe_n: LOW_IDLE,
      mem_fill_req: 1'b0, mem_write_req: 1'b0, line_addr: '0,
      access_hit: 1'b0, sram_way: 1'b0,
      sram_array_write_ctl_n: LOW_IDLE, line_write_policy: POLICY_WT};

   ctl_type                ctl_reg;
   ctl_type                ctl_next;
   logic [SET_WIDTH-1:0]   st_addr;
   logic                   st_wr;
   entry_type              st_wdata;
   logic [ENTRY_WIDTH-1:0] st_rdata;

   // -----------------------------------------------------------------
   // tag and state store
   // -----------------------------------------------------------------
   tag_store #(
      .ADDR_BITS (SET_WIDTH),
      .DATA_BITS (ENTRY_WIDTH)
   ) u_tags (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .addr    (st_addr),
      .wr_en   (st_wr),
      .wr_data (st_wdata),
      .rd_data (st_rdata)
   );

   // -----------------------------------------------------------------
   // control state machine
   // -----------------------------------------------------------------
   always_comb begin
      entry_type e;
      line_type  l;
      logic      hit0;
      logic      hit1;
      logic      vic;
      e    = entry_type'(st_rdata);
      l    = '0;
      hit0 = 1'b0;
      hit1 = 1'b0;
      vic  = 1'b0;
      ctl_next = ctl_reg;
      st_addr  = ctl_reg.idx;
      st_wr    = 1'b0;
      st_wdata = ctl_reg.entry;
      // one-cycle strobes fall back to idle
      ctl_next.inquire_strobe_n       = LOW_IDLE;
      ctl_next.sram_array_write_ctl_n = LOW_IDLE;
      ctl_next.access_hit             = 1'b0;
      ctl_next.sync_prev_n            = sync_req_n;
      case (ctl_reg.fsm)
         // clear every entry to invalid after reset
         CTL_INIT: begin
            st_wr    = 1'b1;
            st_wdata = '0;
            ctl_next.idx = ctl_reg.idx + SET_STEP;
            if (ctl_reg.idx == SET_LAST) begin
               ctl_next.fsm       = CTL_IDLE;
               ctl_next.ctl_ready = 1'b1;
            end
         end
         // sync request on its falling edge, else a processor strobe
         CTL_IDLE: begin
            if (!sync_req_n && ctl_reg.sync_prev_n) begin
               ctl_next.fsm       = CTL_SW_READ;
               ctl_next.idx       = SET_FIRST;
               ctl_next.way       = 1'b0;
               ctl_next.sync_busy = 1'b1;
               ctl_next.ctl_ready = 1'b0;
            end else if (!cpu_address_strobe_n) begin
               // write-versus-read is taken with the strobe
               ctl_next.wr  = cpu_write_read;
               ctl_next.tag = cpu_addr[TAG_WIDTH+SET_WIDTH-1:SET_WIDTH];
               ctl_next.idx = cpu_addr[SET_WIDTH-1:0];
               st_addr      = cpu_addr[SET_WIDTH-1:0];
               ctl_next.fsm       = CTL_LOOKUP;
               ctl_next.ctl_ready = 1'b0;
            end
         end
         // compare both ways, hit updates recent use, and state on a write
         CTL_LOOKUP: begin
            hit0 = (e.way0.coh != COH_INVALID) && (e.way0.tag == ctl_reg.tag);
            hit1 = (e.way1.coh != COH_INVALID) && (e.way1.tag == ctl_reg.tag);
            if (hit0 || hit1) begin
               l = get_line(e, hit1);
               if (ctl_reg.wr) begin
                  l.coh = COH_MOD;          // written line now held here
               end
               e = put_line(e, hit1, l);
               e.recent_use_bit = hit1;
               st_wr    = 1'b1;
               st_wdata = e;
               ctl_next.entry      = e;
               ctl_next.way        = hit1;
               ctl_next.sram_way   = hit1;
               ctl_next.sram_array_write_ctl_n = LOW_ACTIVE;
               ctl_next.access_hit = 1'b1;
               ctl_next.fsm        = CTL_IDLE;
               ctl_next.ctl_ready  = 1'b1;
            end else begin
               if (e.way0.coh == COH_INVALID) begin
                  vic = 1'b0;
               end else if (e.way1.coh == COH_INVALID) begin
                  vic = 1'b1;
               end else begin
                  vic = ~e.recent_use_bit;
               end
               ctl_next.entry        = e;
               ctl_next.way          = vic;
               ctl_next.sram_way     = vic;
               ctl_next.mem_fill_req = 1'b1;
               ctl_next.line_addr    = {ctl_reg.tag, ctl_reg.idx};
               ctl_next.fsm          = CTL_FILL;
            end
         end
         // fill lands: install line, drive write policy for this line
         CTL_FILL: begin
            if (mem_fill_done) begin
               l.tag = ctl_reg.tag;
               l.coh = ctl_reg.wr ? COH_MOD : COH_EXCL;
               e = put_line(ctl_reg.entry, ctl_reg.way, l);
               e.recent_use_bit = ctl_reg.way;
               st_wr    = 1'b1;
               st_wdata = e;
               ctl_next.entry        = e;
               ctl_next.mem_fill_req = 1'b0;
               ctl_next.sram_array_write_ctl_n = LOW_ACTIVE;
               // writeback only when the line is already modified
               // here; otherwise the processor keeps it shared and
               // its first write goes through
               ctl_next.line_write_policy =
                  ctl_reg.wr ? POLICY_WB : POLICY_WT;
               ctl_next.fsm       = CTL_IDLE;
               ctl_next.ctl_ready = 1'b1;
            end
         end
         // sweep: present set address, capture entry next cycle
         CTL_SW_READ: begin
            ctl_next.fsm = CTL_SW_LOAD;
         end
         CTL_SW_LOAD: begin
            ctl_next.entry = e;
            ctl_next.fsm   = CTL_SW_CHECK;
         end
         // modified line goes to inquire; others untouched
         CTL_SW_CHECK: begin
            l = get_line(ctl_reg.entry, ctl_reg.way);
            if (l.coh == COH_MOD) begin
               ctl_next.line_addr        = {l.tag, ctl_reg.idx};
               ctl_next.inquire_strobe_n = LOW_ACTIVE;
               ctl_next.fsm              = CTL_SW_INQ;
            end else if (!ctl_reg.way) begin
               ctl_next.way = 1'b1;
            end else if (ctl_reg.idx == SET_LAST) begin
               ctl_next.fsm = CTL_SW_DONE;
            end else begin
               ctl_next.idx = ctl_reg.idx + SET_STEP;
               ctl_next.way = 1'b0;
               ctl_next.fsm = CTL_SW_READ;
            end
         end
         // processor copy goes into the array in the same cycle the memory write starts
         CTL_SW_INQ: begin
            if (cpu_inquire_done) begin
               ctl_next.sram_way      = ctl_reg.way;
               ctl_next.sram_array_write_ctl_n = LOW_ACTIVE;
               ctl_next.mem_write_req = 1'b1;
               ctl_next.fsm           = CTL_SW_MEMW;
            end
         end
         // line out on the memory bus: drop to exclusive
         CTL_SW_MEMW: begin
            if (mem_write_done) begin
               l     = get_line(ctl_reg.entry, ctl_reg.way);
               l.coh = COH_EXCL;
               e     = put_line(ctl_reg.entry, ctl_reg.way, l);
               st_wr    = 1'b1;
               st_wdata = e;
               ctl_next.entry         = e;
               ctl_next.mem_write_req = 1'b0;
               ctl_next.fsm           = CTL_SW_CHECK;
            end
         end
         // completion only after the last memory write
         CTL_SW_DONE: begin
            ctl_next.sync_busy = 1'b0;
            ctl_next.ctl_ready = 1'b1;
            ctl_next.fsm       = CTL_IDLE;
         end
         default: begin
            ctl_next = CTL_RESET;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_reg <= CTL_RESET;
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs straight from the state register
   // -----------------------------------------------------------------
   assign sync_busy              = ctl_reg.sync_busy;
   assign ctl_ready              = ctl_reg.ctl_ready;
   assign inquire_strobe_n       = ctl_reg.inquire_strobe_n;
   assign mem_fill_req           = ctl_reg.mem_fill_req;
   assign mem_write_req          = ctl_reg.mem_write_req;
   assign line_addr              = ctl_reg.line_addr;
   assign access_hit             = ctl_reg.access_hit;
   assign sram_way               = ctl_reg.sram_way;
   assign sram_array_write_ctl_n = ctl_reg.sram_array_write_ctl_n;
   assign line_write_policy      = ctl_reg.line_write_policy;

endmodule

`default_nettype wire

// ===== tb/cache_sync_ctl_properties.sv
// Purpose: port checks of sweep, fill policy and array write pulses
// Assumes: one clock domain, reset_n asynchronous active low
// Notes:   bound into cache_sync_ctl after the module
`timescale 1ns/10ps
`default_nettype none
module cache_sync_ctl_properties
   import cache_sync_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic sync_req_n,
   input wire logic cpu_address_strobe_n,
   input wire logic cpu_write_read,
   input wire logic cpu_inquire_done,
   input wire logic mem_write_done,
   input wire logic sync_busy,
   input wire logic ctl_ready,
   input wire logic inquire_strobe_n,
   input wire logic mem_fill_req,
   input wire logic mem_write_req,
   input wire logic access_hit,
   input wire logic sram_array_write_ctl_n,
   input wire logic line_write_policy
);
   typedef struct packed {logic sync_prev; logic pend_wr;} watch_type;
   watch_type watch_reg;
   watch_type watch_next;
   logic      start;
   logic      take;

   // sweep start and access take as the controller should see them
   assign start = ctl_ready && !sync_req_n && watch_reg.sync_prev;
   assign take = ctl_ready && !cpu_address_strobe_n && !start;

   // previous request level and direction of the last taken access
   always_comb begin
      watch_next.sync_prev = sync_req_n;
      watch_next.pend_wr = take ? cpu_write_read : watch_reg.pend_wr;
   end

   // helper state register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         watch_reg <= '0;
      end else begin
         watch_reg <= watch_next;
      end
   end

   default clocking main_clk @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   // inquiry pulse stands one cycle, inside a sweep
   sequence s_inquire;
      sync_busy ##1 inquire_strobe_n;
   endsequence
   // processor copy lands in the array in the same cycle the memory write starts
   sequence s_wb_write;
      ##1 (!sram_array_write_ctl_n && mem_write_req);
   endsequence

   // sweep, fill and access relations
   chk_busy_start: assert property (start |=> sync_busy)
      else $error("sweep did not start");
   chk_inq_pulse: assert property (!inquire_strobe_n |-> s_inquire)
      else $error("inquiry pulse malformed");
   chk_wb_write: assert property (
      sync_busy && cpu_inquire_done |-> s_wb_write)
      else $error("writeback not followed by memory write");
   chk_write_cause: assert property (
      $rose(mem_write_req) |-> $past(cpu_inquire_done))
      else $error("memory write without inquiry");
   chk_write_drop: assert property (
      mem_write_req && mem_write_done |=> !mem_write_req)
      else $error("memory write request held");
   chk_sweep_end: assert property (
      $fell(sync_busy) |-> !$past(mem_write_req))
      else $error("sweep ended with write open");
   chk_idle_quiet: assert property (
      !sync_busy |-> !mem_write_req && inquire_strobe_n)
      else $error("sweep traffic while idle");
   chk_hit_array: assert property (
      access_hit |-> !sram_array_write_ctl_n && ctl_ready)
      else $error("hit without array update");
   chk_fill_policy: assert property (
      $fell(mem_fill_req) && !sync_busy |->
      line_write_policy == watch_reg.pend_wr && !sram_array_write_ctl_n)
      else $error("fill policy or array write wrong");
endmodule

bind cache_sync_ctl cache_sync_ctl_properties u_cache_sync_ctl_properties (
   .ref_clk, .reset_n, .sync_req_n, .cpu_address_strobe_n, .cpu_write_read,
   .cpu_inquire_done, .mem_write_done, .sync_busy, .ctl_ready,
   .inquire_strobe_n, .mem_fill_req, .mem_write_req, .access_hit,
   .sram_array_write_ctl_n, .line_write_policy
);
`default_nettype wire

// ===== tb/far_side.sv
// Purpose: processor and memory bus side seen by the controller
// Assumes: done answers are one-cycle pulses, slow adds five cycles
// Notes:   logs memory write addresses for the bench
`timescale 1ns/10ps
`default_nettype none
module far_side
   import cache_sync_pkg::*;
(
   input wire logic                           ref_clk,
   input wire logic                           reset_n,
   input wire logic                           slow,
   input wire logic                           inquire_strobe_n,
   input wire logic                           mem_fill_req,
   input wire logic                           mem_write_req,
   input wire logic                           line_write_policy,
   input wire logic [TAG_WIDTH+SET_WIDTH-1:0] line_addr,
   output var logic                           cpu_inquire_done,
   output var logic                           mem_fill_done,
   output var logic                           mem_write_done
);
   int   delay;
   int   inq_wait;
   int   mem_wait;
   int   inq_count;
   int   write_count;
   logic inq_pend;
   logic fill_seen;
   logic l1_exclusive;
   logic [TAG_WIDTH+SET_WIDTH-1:0] write_log [0:7];

   always_comb delay = slow ? 5 : 0;

   // processor writes its own copy back after an inquiry
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         inq_pend <= 1'h0;
         inq_wait <= 0;
         inq_count <= 0;
         cpu_inquire_done <= 1'h0;
      end else begin
         cpu_inquire_done <= 1'h0;
         if (!inquire_strobe_n) begin
            inq_pend <= 1'h1;
            inq_count <= inq_count + 1;
         end else if (inq_pend) begin
            inq_wait <= inq_wait + 1;
            if (inq_wait >= delay) begin
               cpu_inquire_done <= 1'h1;
               inq_pend <= 1'h0;
               inq_wait <= 0;
            end
         end
      end
   end

   // memory bus ends a fill or write; first-level state from policy
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_wait <= 0;
         write_count <= 0;
         mem_fill_done <= 1'h0;
         mem_write_done <= 1'h0;
         fill_seen <= 1'h0;
         l1_exclusive <= 1'h0;
      end else begin
         mem_fill_done <= 1'h0;
         mem_write_done <= 1'h0;
         fill_seen <= mem_fill_done;
         if (fill_seen) l1_exclusive <= line_write_policy;
         if ((mem_fill_req || mem_write_req) && !mem_fill_done
             && !mem_write_done) begin
            mem_wait <= mem_wait + 1;
            if (mem_wait >= delay) begin
               mem_wait <= 0;
               mem_fill_done <= mem_fill_req;
               mem_write_done <= mem_write_req;
               if (mem_write_req) write_log[write_count % 8] <= line_addr;
               write_count <= write_count + (mem_write_req ? 1 : 0);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/cache_sync_ctl_test.sv
// Purpose: self-checking bench for the sweep and fill policy control
// Assumes: far_side answers inquiries, fills and memory writes
// Notes:   tag clear is 2048 cycles, each sweep about 8192 more
`timescale 1ns/10ps
`default_nettype none
module cache_sync_ctl_test
   import cache_sync_pkg::*;
;
   localparam int AW = TAG_WIDTH + SET_WIDTH;
   logic          ref_clk = 1'h0;
   logic          reset_n = 1'h0;
   logic          sync_req_n = 1'h1;
   logic          cpu_address_strobe_n = 1'h1;
   logic          cpu_write_read = 1'h0;
   logic [AW-1:0] cpu_addr = '0;
   logic          slow = 1'h0;
   logic          last_hit;
   logic          cpu_inquire_done, mem_fill_done, mem_write_done;
   logic          sync_busy, ctl_ready, inquire_strobe_n, mem_fill_req;
   logic          mem_write_req, access_hit, sram_way, line_write_policy;
   logic          sram_array_write_ctl_n;
   logic [AW-1:0] line_addr;
   int            fails = 0;
   int            checks_done = 0;
   // two ways of set 005, two of set 007, one line of the last set
   logic [AW-1:0] tbl_addr [0:4] = '{{12'h001, 11'h005},
      {12'h002, 11'h005}, {12'h004, 11'h007}, {12'h005, 11'h007},
      {12'h003, 11'h7FF}};
   logic [4:0]    tbl_wr = 5'h1D;   // entry 1 is the only read fill
   logic [4:0]    tbl_way = 5'h0A;  // invalid way0 fills before way1

   always #2.5 ref_clk = ~ref_clk;

   cache_sync_ctl u_cache_sync_ctl (.ref_clk, .reset_n, .sync_req_n,
      .cpu_address_strobe_n, .cpu_write_read, .cpu_addr, .cpu_inquire_done,
      .mem_fill_done, .mem_write_done, .sync_busy, .ctl_ready,
      .inquire_strobe_n, .mem_fill_req, .mem_write_req, .line_addr,
      .access_hit, .sram_way, .sram_array_write_ctl_n, .line_write_policy);
   far_side u_far_side (.ref_clk, .reset_n, .slow, .inquire_strobe_n,
      .mem_fill_req, .mem_write_req, .line_write_policy, .line_addr,
      .cpu_inquire_done, .mem_fill_done, .mem_write_done);

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic finish_test;
      if (fails == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one access, direction valid with the strobe
   task automatic access(input logic wr, input logic [AW-1:0] a);
      last_hit = 1'h0;
      @(posedge ref_clk);
      cpu_address_strobe_n <= 1'h0;
      cpu_write_read <= wr;
      cpu_addr <= a;
      @(posedge ref_clk);
      cpu_address_strobe_n <= 1'h1;
      for (int n = 0; n < 99; n++) begin
         @(posedge ref_clk);
         #1;
         last_hit = last_hit | access_hit;
         if (ctl_ready === 1'h1 && n > 0) break;
      end
   endtask

   // fill every table line, or read every one back
   task automatic probe(input logic reads);
      for (int i = 0; i < 5; i++) begin
         access(reads ? 1'h0 : tbl_wr[i], tbl_addr[i]);
         check(last_hit, reads);
         check(sram_way, tbl_way[i]);
         if (!reads) check(line_write_policy, tbl_wr[i]);
         if (!reads) begin
            @(posedge ref_clk);
            #1;
            check(u_far_side.l1_exclusive, tbl_wr[i]);
         end
      end
   endtask

   // one sweep: dirty lines written in set and way order, all still hit
   task automatic test_sweep(input logic slow_far, input int dirty);
      int w0;
      int q0;
      int busy;
      w0 = u_far_side.write_count;
      q0 = u_far_side.inq_count;
      busy = 0;
      @(posedge ref_clk);
      slow <= slow_far;
      sync_req_n <= 1'h0;
      @(posedge ref_clk);
      #1;
      check(sync_busy, 1'h1);
      while (sync_busy === 1'h1 && busy < 20000) begin
         @(posedge ref_clk);
         #1;
         busy++;
      end
      check(u_far_side.write_count - w0, dirty);
      check(u_far_side.inq_count - q0, dirty);
      check(busy >= 8188, 1'h1);
      if (dirty == 0) check(busy, 4 * (1 << SET_WIDTH) + 1);
      for (int i = 0; i < dirty; i++) begin
         check(u_far_side.write_log[(w0 + i) % 8],
               tbl_addr[i == 0 ? 0 : i + 1]);
      end
      @(posedge ref_clk);
      sync_req_n <= 1'h1;
      probe(1'h1);
   endtask

   // reset, wait out the tag clear, run the scenarios
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'h1;
      for (int n = 0; n < 3000 && ctl_ready !== 1'h1; n++) begin
         @(posedge ref_clk);
         #1;
      end
      probe(1'h0);
      test_sweep(1'h1, 4);
      test_sweep(1'h0, 0);
      finish_test;
   end

   // watchdog well beyond two sweeps and the clear
   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      finish_test;
   end
endmodule
`default_nettype wire
